/* can_filt_pkg.sv */
// Contract
// - for an extended frame, a filter matches only if each compared extended id bit 17..0 equals its pattern bit
// - mask source code 00, 01, 10 picks acceptance mask 0, 1, 2
// - mask source code 11 means no mask; every id bit is compared
// - low select register holds filters 0..7, filter n at bits 2n+1..2n
// - a filter matches only if each compared base id bit equals its pattern bit
// - with format check on, the frame format must equal the filter format bit
// - with format check off, the filter format bit is ignored
// - a mask bit of 1 includes the id bit, 0 makes it don't-care
package can_filt_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // ===========================================
  // register map, word index on the address port
  localparam logic [7:0] FILT_BASE_OFS = 8'h00;
  localparam logic [7:0] FILT_EXT_OFS = 8'h10;
  localparam logic [7:0] MASK_BASE_OFS = 8'h20;
  localparam logic [7:0] MASK_EXT_OFS = 8'h24;
  localparam logic [7:0] SEL_LOW_OFS = 8'h28;
  localparam logic [7:0] SEL_HIGH_OFS = 8'h29;
  localparam logic [7:0] HIT_STATUS_OFS = 8'h2a;
  localparam logic [7:0] HIT_INDEX_OFS = 8'h2b;
  // ===========================================
  // field layout of the base-id pattern and mask words
  localparam int BASE_ID_MSB = 15;
  localparam int BASE_ID_LSB = 5;
  localparam int FORMAT_BIT = 3;
  localparam int EXT_HI_MSB = 1;
  // bits 4 and 2 are unimplemented and read as zero
  localparam logic [15:0] BASE_WORD_WMASK = 16'hffeb;
  // ===========================================
  // reset values
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;
  // ===========================================
  typedef enum logic [1:0] {
    SRC_MASK0 = 2'b00,
    SRC_MASK1 = 2'b01,
    SRC_MASK2 = 2'b10,
    SRC_NONE = 2'b11
  } mask_src_e;
endpackage : can_filt_pkg

/* mask_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mask_link_if;
  logic [15:0] base_mask;
  logic [15:0] ext_mask;
  logic no_mask;
  modport src (output base_mask, output ext_mask, output no_mask);
  modport dst (input base_mask, input ext_mask, input no_mask);
endinterface : mask_link_if
`default_nettype wire

/* mask_picker.sv */
`timescale 1ns/1ps
`default_nettype none
module mask_picker import can_filt_pkg::*; (
  input wire logic [2:0][15:0] mask_base,
  input wire logic [2:0][15:0] mask_ext,
  input wire logic [1:0] filter_mask_source,
  mask_link_if.src link
);
  always_comb begin
    link.no_mask = 1'b0;
    unique case (mask_src_e'(filter_mask_source))
      SRC_MASK0: begin
        link.base_mask = mask_base[0];
        link.ext_mask = mask_ext[0];
      end
      SRC_MASK1: begin
        link.base_mask = mask_base[1];
        link.ext_mask = mask_ext[1];
      end
      SRC_MASK2: begin
        link.base_mask = mask_base[2];
        link.ext_mask = mask_ext[2];
      end
      SRC_NONE: begin
        link.base_mask = BASE_WORD_WMASK;
        link.ext_mask = 16'hffff;
        link.no_mask = 1'b1;
      end
    endcase
  end
endmodule : mask_picker
`default_nettype wire

/* filter_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module filter_compare import can_filt_pkg::*; (
  input wire logic [15:0] filter_base_match_bits,
  input wire logic [15:0] filter_ext_match_bits,
  input wire logic [10:0] base_identifier_bits,
  input wire logic [17:0] extended_identifier_bits,
  input wire logic frame_is_ext,
  mask_link_if.dst link,
  output logic hit
);
  logic [10:0] care_base;
  logic [17:0] care_ext;
  logic [17:0] pat_ext;
  logic base_ok;
  logic ext_ok;
  logic fmt_check;
  logic fmt_ok;
  always_comb begin
    care_base = link.base_mask[BASE_ID_MSB:BASE_ID_LSB];
    care_ext = {link.base_mask[EXT_HI_MSB:0], link.ext_mask};
    pat_ext = {filter_base_match_bits[EXT_HI_MSB:0], filter_ext_match_bits};
    base_ok = ((base_identifier_bits ^ filter_base_match_bits[BASE_ID_MSB:BASE_ID_LSB]) & care_base) == 11'h000;
    // a base-format frame carries no extended bits, so they cannot take part
    ext_ok = !frame_is_ext || (((extended_identifier_bits ^ pat_ext) & care_ext) == 18'h00000);
    // with no mask the format bit is compared like every other bit
    fmt_check = link.no_mask || link.base_mask[FORMAT_BIT];
    fmt_ok = !fmt_check || (frame_is_ext == filter_base_match_bits[FORMAT_BIT]);
    hit = base_ok && ext_ok && fmt_ok;
  end
endmodule : filter_compare
`default_nettype wire

/* can_acceptance_filter_match.sv */
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_match import can_filt_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic id_valid,
  input wire logic [10:0] base_identifier_bits,
  input wire logic [17:0] extended_identifier_bits,
  input wire logic id_is_ext,
  output logic match_valid,
  output logic [15:0] match_hits,
  output logic match_any,
  output logic [3:0] match_index
);
  // ===========================================
  // state
  typedef struct packed {
    logic [15:0][15:0] filt_base;
    logic [15:0][15:0] filt_ext;
    logic [2:0][15:0] mask_base;
    logic [2:0][15:0] mask_ext;
    logic [15:0] sel_low;
    logic [15:0] sel_high;
    logic [15:0] rdata;
    logic valid;
    logic [15:0] hits;
    logic any;
    logic [3:0] index;
  } state_s;

  state_s state_q;
  state_s state_d;
  logic [15:0] hit_now;

  // ===========================================
  // decoding used by the comparators and the hit index
  function automatic logic [1:0] mask_source_of(input logic [15:0] lo, input logic [15:0] hi, input int n);
    logic [15:0] word;
    int slot;
    word = (n < 8) ? lo : hi;
    slot = n % 8;
    return word[2*slot +: 2];
  endfunction : mask_source_of

  function automatic logic [3:0] first_hit(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_hit

  // ===========================================
  // one mask picker and one comparator per filter
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : g_filter
      mask_link_if link ();
      mask_picker u_pick (
        .mask_base(state_q.mask_base),
        .mask_ext(state_q.mask_ext),
        .filter_mask_source(mask_source_of(state_q.sel_low, state_q.sel_high, g)),
        .link(link)
      );
      filter_compare u_cmp (
        .filter_base_match_bits(state_q.filt_base[g]),
        .filter_ext_match_bits(state_q.filt_ext[g]),
        .base_identifier_bits(base_identifier_bits),
        .extended_identifier_bits(extended_identifier_bits),
        .frame_is_ext(id_is_ext),
        .link(link),
        .hit(hit_now[g])
      );
    end
  endgenerate

  // ===========================================
  // next state
  always_comb begin
    state_d = state_q;
    state_d.rdata = READ_IDLE;
    state_d.valid = 1'b0;
    // result lands one cycle after the identifier; status holds the last result
    if (id_valid) begin
      state_d.valid = 1'b1;
      state_d.hits = hit_now;
      state_d.any = |hit_now;
      state_d.index = first_hit(hit_now);
    end
    if (reg_wr) begin
      if (reg_addr >= FILT_BASE_OFS && reg_addr < FILT_EXT_OFS) begin
        state_d.filt_base[reg_addr[3:0]] = reg_wdata & BASE_WORD_WMASK;
      end else if (reg_addr >= FILT_EXT_OFS && reg_addr < MASK_BASE_OFS) begin
        state_d.filt_ext[reg_addr[3:0]] = reg_wdata;
      end else if (reg_addr >= MASK_BASE_OFS && reg_addr < MASK_BASE_OFS + 8'(NUM_MASKS)) begin
        state_d.mask_base[2'(reg_addr - MASK_BASE_OFS)] = reg_wdata & BASE_WORD_WMASK;
      end else if (reg_addr >= MASK_EXT_OFS && reg_addr < MASK_EXT_OFS + 8'(NUM_MASKS)) begin
        state_d.mask_ext[2'(reg_addr - MASK_EXT_OFS)] = reg_wdata;
      end else if (reg_addr == SEL_LOW_OFS) begin
        state_d.sel_low = reg_wdata;
      end else if (reg_addr == SEL_HIGH_OFS) begin
        state_d.sel_high = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr >= FILT_BASE_OFS && reg_addr < FILT_EXT_OFS) begin
        state_d.rdata = state_q.filt_base[reg_addr[3:0]];
      end else if (reg_addr >= FILT_EXT_OFS && reg_addr < MASK_BASE_OFS) begin
        state_d.rdata = state_q.filt_ext[reg_addr[3:0]];
      end else if (reg_addr >= MASK_BASE_OFS && reg_addr < MASK_BASE_OFS + 8'(NUM_MASKS)) begin
        state_d.rdata = state_q.mask_base[2'(reg_addr - MASK_BASE_OFS)];
      end else if (reg_addr >= MASK_EXT_OFS && reg_addr < MASK_EXT_OFS + 8'(NUM_MASKS)) begin
        state_d.rdata = state_q.mask_ext[2'(reg_addr - MASK_EXT_OFS)];
      end else if (reg_addr == SEL_LOW_OFS) begin
        state_d.rdata = state_q.sel_low;
      end else if (reg_addr == SEL_HIGH_OFS) begin
        state_d.rdata = state_q.sel_high;
      end else if (reg_addr == HIT_STATUS_OFS) begin
        state_d.rdata = state_q.hits;
      end else if (reg_addr == HIT_INDEX_OFS) begin
        state_d.rdata = {11'h000, state_q.any, state_q.index};
      end
    end
  end

  // ===========================================
  // registers; patterns power up undefined in silicon, cleared here for determinism
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q.filt_base <= '0;
      state_q.filt_ext <= '0;
      state_q.mask_base <= '0;
      state_q.mask_ext <= '0;
      state_q.sel_low <= SEL_RESET;
      state_q.sel_high <= SEL_RESET;
      state_q.rdata <= READ_IDLE;
      state_q.valid <= 1'b0;
      state_q.hits <= PATTERN_RESET;
      state_q.any <= 1'b0;
      state_q.index <= 4'h0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign match_valid = state_q.valid;
  assign match_hits = state_q.hits;
  assign match_any = state_q.any;
  assign match_index = state_q.index;
endmodule : can_acceptance_filter_match
`default_nettype wire

/* can_filt_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module can_filt_monitor import can_filt_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic id_valid,
  input wire logic match_valid,
  input wire logic [15:0] match_hits,
  input wire logic match_any,
  input wire logic [3:0] match_index
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ====
  // sequences and checks
  sequence s_lone_id; id_valid ##1 !id_valid; endsequence
  sequence s_sel_wr_rd; reg_wr && reg_addr == SEL_LOW_OFS ##1 reg_rd && reg_addr == SEL_LOW_OFS; endsequence
  chk_valid_follows: assert property (id_valid |=> match_valid)
    else $error("no result after id");
  chk_valid_single: assert property (s_lone_id |=> !match_valid)
    else $error("result pulse too long");
  chk_hits_hold: assert property (!id_valid |=> $stable(match_hits) && $stable(match_index))
    else $error("result changed without id");
  chk_any_or: assert property (match_valid |-> match_any == (match_hits != 16'h0000))
    else $error("any flag wrong");
  chk_index_lowest: assert property (match_valid && match_any |-> match_hits[match_index] &&
    ((match_hits & ((16'h0001 << match_index) - 16'h0001)) == 16'h0000))
    else $error("index not lowest hit");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > HIT_INDEX_OFS |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_sel_readback: assert property (s_sel_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("select readback wrong");
  chk_fmt_bits_zero: assert property (reg_rd && reg_addr < FILT_EXT_OFS |=> !reg_rdata[4] && !reg_rdata[2])
    else $error("unused pattern bits set");
endmodule : can_filt_monitor
bind can_acceptance_filter_match can_filt_monitor can_filt_monitor_i (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .id_valid(id_valid), .match_valid(match_valid), .match_hits(match_hits), .match_any(match_any),
  .match_index(match_index));
`default_nettype wire

/* can_id_source.sv */
`timescale 1ns/1ps
`default_nettype none
module can_id_source (
  input wire logic core_clk,
  output logic valid,
  output logic [10:0] base_id,
  output logic [17:0] ext_id,
  output logic is_ext
);
  initial begin
    valid = 1'b0;
    {base_id, ext_id, is_ext} = 30'h0;
  end
  // ====
  // lines go inverted after the pulse so a stale id never passes for a fresh one
  task automatic send(input logic [10:0] b, input logic [17:0] e, input logic x);
    @(posedge core_clk);
    valid <= 1'b1;
    {base_id, ext_id, is_ext} <= {b, e, x};
    @(posedge core_clk);
    valid <= 1'b0;
    {base_id, ext_id, is_ext} <= ~{b, e, x};
  endtask : send
endmodule : can_id_source
`default_nettype wire

/* can_acceptance_filter_match_test.sv */
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_match_test import can_filt_pkg::*;;
  logic core_clk, reset, reg_wr, reg_rd, id_valid, is_ext, match_valid, match_any;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, match_hits;
  logic [10:0] base_id;
  logic [17:0] ext_id;
  logic [3:0] match_index;
  int n_mismatch, checks_done;
  can_acceptance_filter_match can_acceptance_filter_match_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .id_valid(id_valid), .base_identifier_bits(base_id), .extended_identifier_bits(ext_id),
    .id_is_ext(is_ext), .match_valid(match_valid), .match_hits(match_hits), .match_any(match_any),
    .match_index(match_index));
  can_id_source can_id_source_i (.core_clk(core_clk), .valid(id_valid), .base_id(base_id),
    .ext_id(ext_id), .is_ext(is_ext));
  // ====
  // helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000);
    #1 cmp(reg_rdata, e);
  endtask : rd
  // expected index is the lowest hit, zero when nothing hit
  task automatic id_chk(input logic [10:0] b, input logic [17:0] e, input logic x, input logic [15:0] h);
    int i;
    bus(1'b0, 1'b0, 8'h00, 16'h0000);
    can_id_source_i.send(b, e, x);
    #1 cmp({15'h0000, match_valid}, 16'h0001);
    cmp(match_hits, h);
    cmp({15'h0000, match_any}, {15'h0000, h != 16'h0000});
    for (i = 0; i < 16 && !h[i]; i++) begin end
    cmp({12'h000, match_index}, {12'h000, i[3:0]});
  endtask : id_chk
  // ====
  // scenarios
  task automatic t_reset_state();
    rd(SEL_LOW_OFS, SEL_RESET);
    rd(SEL_HIGH_OFS, SEL_RESET);
    id_chk(11'h5a5, 18'h3c3c3, 1'b1, 16'hffff);
  endtask : t_reset_state
  task automatic t_program();
    wr(MASK_BASE_OFS + 8'h01, 16'hffe3);
    wr(MASK_EXT_OFS + 8'h01, 16'hffff);
    wr(MASK_BASE_OFS + 8'h02, 16'h0008);
    wr(FILT_BASE_OFS + 8'h09, 16'h2460);
    wr(FILT_EXT_OFS + 8'h09, 16'hbeef);
    wr(FILT_BASE_OFS + 8'h0c, 16'h0008);
    wr(FILT_BASE_OFS + 8'h0f, 16'h0034);
    wr(SEL_HIGH_OFS, 16'h0204);
    wr(SEL_LOW_OFS, 16'h00c3);
    rd(SEL_LOW_OFS, 16'h00c3);
    rd(SEL_HIGH_OFS, 16'h0204);
    rd(FILT_BASE_OFS + 8'h0f, 16'h0020);
    rd(8'hff, READ_IDLE);
  endtask : t_program
  task automatic t_masked();
    id_chk(11'h123, 18'h0beef, 1'b1, 16'hfff6);
    id_chk(11'h123, 18'h0beee, 1'b1, 16'hfdf6);
    id_chk(11'h122, 18'h0beef, 1'b1, 16'hfdf6);
    id_chk(11'h123, 18'h1beef, 1'b1, 16'hfdf6);
  endtask : t_masked
  task automatic t_format();
    id_chk(11'h123, 18'h0beef, 1'b0, 16'heff6);
    id_chk(11'h000, 18'h3ffff, 1'b0, 16'hedff);
    id_chk(11'h000, 18'h00000, 1'b1, 16'hfdf6);
  endtask : t_format
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 2'b00, 8'h00, 16'h0000};
    n_mismatch = 0;
    checks_done = 0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_state();
    t_program();
    t_masked();
    t_format();
    report_and_stop();
  end
endmodule : can_acceptance_filter_match_test
`default_nettype wire
